// ### rtl/serial_tunnel_port_processor.v
// Added by the designer: register access over Wishbone and the address map.
`include "serial_tunnel_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module serial_tunnel_port_processor #(
    parameter [15:0] CYC_PER_MS = `MS_CYCLES
) (
    // Clock and reset
    input wire clk_i,
    input wire arst_n_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Serial line
    input wire rxd_i,
    output reg txd_o,
    input wire rts_i,
    output reg cts_o,
    input wire dtr_i,
    output reg dsr_o,
    output reg dcd_o,
    // Peer request
    input wire link_req_i,
    output reg link_req_o,
    // Received packet stream
    output reg [7:0] pkt_data_o,
    output reg pkt_valid_o,
    output reg pkt_end_o,
    // Transmit byte stream
    input wire [7:0] tx_data_i,
    input wire tx_valid_i,
    input wire tx_last_i,
    output reg tx_ready_o
);
    localparam RX_IDLE = 3'h0;
    localparam RX_START = 3'h1;
    localparam RX_DATA = 3'h2;
    localparam RX_PAR = 3'h3;
    localparam RX_STOP = 3'h4;
    localparam TX_IDLE = 3'h0;
    localparam TX_HOLD = 3'h1;
    localparam TX_START = 3'h2;
    localparam TX_DATA = 3'h3;
    localparam TX_PAR = 3'h4;
    localparam TX_STOP = 3'h5;

    function [15:0] wr16;
        input [15:0] old;
        input [31:0] d;
        input [3:0] sel;
        begin
            wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    function [7:0] nb_mask;
        input [1:0] nb;
        begin
            case (nb)
                2'h0: nb_mask = 8'h1F;
                2'h1: nb_mask = 8'h3F;
                2'h2: nb_mask = 8'h7F;
                default: nb_mask = 8'hFF;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    reg [15:0] ctrl_ff, baud_ff, lat_ff, txdly_ff, idle_ff, sync1_ff, sync2_ff, hsdly_ff;
    reg [15:0] rxcnt_ff, txcnt_ff;
    wire [7:0] adr = {wb_adr_i[7:2], 2'h0};
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    wire cnt_clr = wb_wr & (adr == `REG_CTRL) & wb_sel_i[0] & wb_dat_i[`CTRL_CNT_CLR];
    wire port_en = ctrl_ff[`CTRL_PORT_EN];
    wire bs_mode = ctrl_ff[`CTRL_BITSTREAM];
    wire frame_mode = ctrl_ff[`CTRL_FRAME] & ~bs_mode;
    wire [1:0] par_sel = ctrl_ff[`CTRL_PAR_HI:`CTRL_PAR_LO];
    wire par_en = (par_sel == `PAR_ODD) | (par_sel == `PAR_EVEN);
    wire [1:0] nb_sel = ctrl_ff[`CTRL_NB_HI:`CTRL_NB_LO];
    wire [3:0] nbits = {2'h0, nb_sel} + 4'h5;
    reg [2:0] rx_st_ff, tx_st_ff;
    reg pkt_open_ff, hs_grant_ff;
    reg [31:0] nxt_dat;

    always @* begin
        nxt_dat = 32'h0;
        case (adr)
            `REG_CTRL: nxt_dat = {16'h0, ctrl_ff};
            `REG_BAUD: nxt_dat = {16'h0, baud_ff};
            `REG_LATENCY: nxt_dat = {16'h0, lat_ff};
            `REG_TXDELAY: nxt_dat = {16'h0, txdly_ff};
            `REG_IDLE: nxt_dat = {16'h0, idle_ff};
            `REG_SYNC1: nxt_dat = {16'h0, sync1_ff};
            `REG_SYNC2: nxt_dat = {16'h0, sync2_ff};
            `REG_HSDELAY: nxt_dat = {16'h0, hsdly_ff};
            `REG_RXCNT: nxt_dat = {16'h0, rxcnt_ff};
            `REG_TXCNT: nxt_dat = {16'h0, txcnt_ff};
            `REG_STATUS: nxt_dat = {26'h0, hs_grant_ff, pkt_open_ff, tx_st_ff != TX_IDLE,
                rx_st_ff != RX_IDLE, txd_o, 1'b0};
            default: nxt_dat = 32'h0;
        endcase
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_ff <= `RST_CTRL;
            baud_ff <= `RST_BAUD;
            lat_ff <= `RST_LATENCY;
            txdly_ff <= `RST_TXDELAY;
            idle_ff <= `RST_IDLE;
            sync1_ff <= `RST_SYNC1;
            sync2_ff <= `RST_SYNC2;
            hsdly_ff <= `RST_HSDELAY;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req & ~wb_we_i ? nxt_dat : 32'h0;
            if (wb_wr) begin
                case (adr)
                    `REG_CTRL: ctrl_ff <= wr16(ctrl_ff, wb_dat_i, wb_sel_i) & `CTRL_MASK;
                    `REG_BAUD: baud_ff <= wr16(baud_ff, wb_dat_i, wb_sel_i);
                    `REG_LATENCY: lat_ff <= wr16(lat_ff, wb_dat_i, wb_sel_i);
                    `REG_TXDELAY: txdly_ff <= wr16(txdly_ff, wb_dat_i, wb_sel_i);
                    `REG_IDLE: idle_ff <= wr16(idle_ff, wb_dat_i, wb_sel_i);
                    `REG_SYNC1: sync1_ff <= wr16(sync1_ff, wb_dat_i, wb_sel_i);
                    `REG_SYNC2: sync2_ff <= wr16(sync2_ff, wb_dat_i, wb_sel_i);
                    `REG_HSDELAY: hsdly_ff <= wr16(hsdly_ff, wb_dat_i, wb_sel_i);
                    default: ;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Input synchronisers and bit tick
    // ---------------------------------------------------------------
    reg [3:0] s1_ff, s2_ff;
    reg [15:0] baud_cnt_ff;
    reg bit_tick_ff;
    wire rxd_s = s2_ff[0];
    wire rts_s = s2_ff[1];
    wire dtr_s = s2_ff[2];
    wire link_s = s2_ff[3];

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_ff <= 4'h1;
            s2_ff <= 4'h1;
            baud_cnt_ff <= 16'h0;
            bit_tick_ff <= 1'b0;
        end else begin
            s1_ff <= {link_req_i, dtr_i, rts_i, rxd_i};
            s2_ff <= s1_ff;
            bit_tick_ff <= (baud_cnt_ff == 16'h0);
            // New divisor takes effect at once
            if (wb_wr & (adr == `REG_BAUD)) begin
                baud_cnt_ff <= 16'h0;
            end else begin
                baud_cnt_ff <= (baud_cnt_ff == 16'h0) ? baud_ff - 16'h1 : baud_cnt_ff - 16'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Handshake lines
    // ---------------------------------------------------------------
    reg [15:0] hs_cnt_ff;
    wire p2p = ctrl_ff[`CTRL_P2P];
    wire rtscts_act = p2p & ctrl_ff[`CTRL_RTSCTS];
    wire dtrdsr_act = p2p & ctrl_ff[`CTRL_DTRDSR] & ~ctrl_ff[`CTRL_RTSCTS];
    wire hs_req = rtscts_act ? rts_s : (dtrdsr_act & dtr_s);
    wire rx_gate = ~(rtscts_act | dtrdsr_act) | hs_grant_ff;

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hs_cnt_ff <= 16'h0;
            hs_grant_ff <= 1'b0;
            cts_o <= 1'b0;
            dsr_o <= 1'b0;
            dcd_o <= 1'b0;
            link_req_o <= 1'b0;
        end else begin
            if (!hs_req) begin
                hs_cnt_ff <= hsdly_ff;
                hs_grant_ff <= 1'b0;
            end else if (!hs_grant_ff) begin
                if (hs_cnt_ff == 16'h0) begin
                    hs_grant_ff <= 1'b1;
                end else if (bit_tick_ff) begin
                    hs_cnt_ff <= hs_cnt_ff - 16'h1;
                end
            end
            cts_o <= rtscts_act & hs_req & hs_grant_ff;
            dsr_o <= dtrdsr_act & hs_req & hs_grant_ff;
            link_req_o <= rtscts_act & rts_s & (ctrl_ff[`CTRL_REMOTE] | hs_grant_ff);
            dcd_o <= p2p & ~ctrl_ff[`CTRL_DTRDSR] & link_s;
        end
    end

    // ---------------------------------------------------------------
    // Receive path
    // ---------------------------------------------------------------
    reg [15:0] rx_cnt_ff, ones_ff, idle_cnt_ff, ms_cnt_ff, ms_el_ff;
    reg [3:0] rx_idx_ff;
    reg [7:0] rx_sh_ff;
    reg bs_open_ff;
    reg rx_stb;
    reg [7:0] rx_byte;
    reg bs_end;

    always @* begin
        rx_stb = 1'b0;
        rx_byte = 8'h0;
        bs_end = 1'b0;
        if (port_en & bs_mode & bit_tick_ff) begin
            if (rx_idx_ff == 4'h7) begin
                rx_stb = 1'b1;
                rx_byte = {rxd_s, rx_sh_ff[7:1]};
            end
            bs_end = rxd_s & bs_open_ff & (ones_ff + 16'h1 >= sync2_ff);
        end else if (rx_st_ff == RX_STOP && rx_cnt_ff == 16'h0) begin
            rx_stb = 1'b1;
            rx_byte = (rx_sh_ff >> (4'h8 - nbits)) & nb_mask(nb_sel);
        end
    end

    wire byte_out = rx_stb & rx_gate;
    wire lat_close = ~frame_mode & (ms_el_ff >= {1'b0, lat_ff[15:1]});
    wire idle_close = frame_mode & (idle_cnt_ff >= idle_ff);
    wire close = pkt_open_ff & ~byte_out & (bs_end | lat_close | idle_close);

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_st_ff <= RX_IDLE;
            rx_cnt_ff <= 16'h0;
            rx_idx_ff <= 4'h0;
            rx_sh_ff <= 8'h0;
            ones_ff <= 16'h0;
            bs_open_ff <= 1'b0;
        end else if (!port_en) begin
            rx_st_ff <= RX_IDLE;
            rx_idx_ff <= 4'h0;
            ones_ff <= 16'h0;
            bs_open_ff <= 1'b0;
        end else if (bs_mode) begin
            rx_st_ff <= RX_IDLE;
            if (bit_tick_ff) begin
                rx_sh_ff <= {rxd_s, rx_sh_ff[7:1]};
                rx_idx_ff <= bs_end ? 4'h0 : {1'b0, rx_idx_ff[2:0] + 3'h1};
                ones_ff <= rxd_s ? ones_ff + 16'h1 : 16'h0;
                bs_open_ff <= bs_end ? 1'b0 : (bs_open_ff | ~rxd_s);
            end
        end else begin
            case (rx_st_ff)
                RX_IDLE: begin
                    if (!rxd_s) begin
                        rx_cnt_ff <= {1'b0, baud_ff[15:1]};
                        rx_st_ff <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_ff == 16'h0) begin
                        rx_cnt_ff <= baud_ff - 16'h1;
                        rx_idx_ff <= 4'h0;
                        rx_st_ff <= rxd_s ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt_ff <= rx_cnt_ff - 16'h1;
                    end
                end
                RX_DATA, RX_PAR: begin
                    if (rx_cnt_ff == 16'h0) begin
                        rx_cnt_ff <= baud_ff - 16'h1;
                        if (rx_st_ff == RX_PAR) begin
                            rx_st_ff <= RX_STOP;
                        end else begin
                            rx_sh_ff <= {rxd_s, rx_sh_ff[7:1]};
                            rx_idx_ff <= rx_idx_ff + 4'h1;
                            if (rx_idx_ff == nbits - 4'h1) begin
                                rx_st_ff <= par_en ? RX_PAR : RX_STOP;
                            end
                        end
                    end else begin
                        rx_cnt_ff <= rx_cnt_ff - 16'h1;
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_ff == 16'h0) begin
                        rx_st_ff <= RX_IDLE;
                    end else begin
                        rx_cnt_ff <= rx_cnt_ff - 16'h1;
                    end
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end

    // Packet window, silence and counters
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pkt_open_ff <= 1'b0;
            pkt_valid_o <= 1'b0;
            pkt_end_o <= 1'b0;
            pkt_data_o <= 8'h0;
            idle_cnt_ff <= 16'h0;
            ms_cnt_ff <= 16'h0;
            ms_el_ff <= 16'h0;
            rxcnt_ff <= 16'h0;
        end else begin
            pkt_valid_o <= byte_out;
            pkt_end_o <= close;
            if (byte_out) begin
                pkt_data_o <= rx_byte;
            end
            if (byte_out) begin
                pkt_open_ff <= 1'b1;
            end else if (close) begin
                pkt_open_ff <= 1'b0;
            end
            if (byte_out | rx_st_ff != RX_IDLE | ~rxd_s) begin
                idle_cnt_ff <= 16'h0;
            end else if (bit_tick_ff & (idle_cnt_ff != 16'hFFFF)) begin
                idle_cnt_ff <= idle_cnt_ff + 16'h1;
            end
            if (~pkt_open_ff) begin
                // First byte cycle counts as part of the window
                ms_cnt_ff <= {15'h0, byte_out};
                ms_el_ff <= 16'h0;
            end else if (ms_cnt_ff == CYC_PER_MS - 16'h1) begin
                ms_cnt_ff <= 16'h0;
                ms_el_ff <= ms_el_ff + 16'h1;
            end else begin
                ms_cnt_ff <= ms_cnt_ff + 16'h1;
            end
            rxcnt_ff <= (cnt_clr ? 16'h0 : rxcnt_ff) + {15'h0, byte_out};
        end
    end

    // ---------------------------------------------------------------
    // Transmit path
    // ---------------------------------------------------------------
    reg [15:0] hold_ff;
    reg [7:0] tx_sh_ff;
    reg [3:0] tx_idx_ff;
    reg tx_par_ff, tx_last_ff, stop2_ff, first_ff, msg_start_ff, gap_ff;
    wire tx_take = tx_st_ff == TX_IDLE & tx_ready_o & tx_valid_i;
    wire [7:0] tx_masked = tx_data_i & nb_mask(nb_sel);
    reg [15:0] nxt_hold;

    always @* begin
        nxt_hold = 16'h0;
        if (bs_mode) begin
            nxt_hold = msg_start_ff ? sync1_ff : 16'h0;
        end else if (first_ff) begin
            nxt_hold = txdly_ff;
        end else if (frame_mode & gap_ff) begin
            nxt_hold = idle_ff;
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_st_ff <= TX_IDLE;
            txd_o <= 1'b1;
            tx_ready_o <= 1'b0;
            hold_ff <= 16'h0;
            tx_sh_ff <= 8'h0;
            tx_idx_ff <= 4'h0;
            tx_par_ff <= 1'b0;
            tx_last_ff <= 1'b0;
            stop2_ff <= 1'b0;
            first_ff <= 1'b1;
            msg_start_ff <= 1'b1;
            gap_ff <= 1'b0;
            txcnt_ff <= 16'h0;
        end else begin
            txcnt_ff <= cnt_clr ? 16'h0 : txcnt_ff;
            if (!port_en) begin
                tx_st_ff <= TX_IDLE;
                txd_o <= 1'b1;
                tx_ready_o <= 1'b0;
                first_ff <= 1'b1;
                msg_start_ff <= 1'b1;
                gap_ff <= 1'b0;
            end else begin
                case (tx_st_ff)
                    TX_IDLE: begin
                        txd_o <= 1'b1;
                        tx_ready_o <= ~tx_take;
                        if (tx_take) begin
                            tx_sh_ff <= bs_mode ? tx_data_i : tx_masked;
                            tx_par_ff <= ^tx_masked ^ (par_sel == `PAR_ODD);
                            tx_last_ff <= tx_last_i;
                            hold_ff <= nxt_hold;
                            first_ff <= 1'b0;
                            msg_start_ff <= 1'b0;
                            gap_ff <= 1'b0;
                            tx_st_ff <= TX_HOLD;
                        end
                    end
                    TX_HOLD: begin
                        if (bit_tick_ff) begin
                            if (hold_ff != 16'h0) begin
                                hold_ff <= hold_ff - 16'h1;
                            end else if (bs_mode) begin
                                txd_o <= tx_sh_ff[0];
                                tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                                tx_idx_ff <= 4'h1;
                                tx_st_ff <= TX_DATA;
                            end else begin
                                txd_o <= 1'b0;
                                tx_st_ff <= TX_START;
                            end
                        end
                    end
                    TX_START: begin
                        if (bit_tick_ff) begin
                            txd_o <= tx_sh_ff[0];
                            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                            tx_idx_ff <= 4'h1;
                            tx_st_ff <= TX_DATA;
                        end
                    end
                    TX_DATA: begin
                        if (bit_tick_ff) begin
                            if (tx_idx_ff == (bs_mode ? 4'h8 : nbits)) begin
                                txd_o <= (par_en & ~bs_mode) ? tx_par_ff : 1'b1;
                                stop2_ff <= ctrl_ff[`CTRL_STOP2];
                                tx_st_ff <= (par_en & ~bs_mode) ? TX_PAR : TX_STOP;
                            end else begin
                                txd_o <= tx_sh_ff[0];
                                tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                                tx_idx_ff <= tx_idx_ff + 4'h1;
                            end
                        end
                    end
                    TX_PAR: begin
                        if (bit_tick_ff) begin
                            txd_o <= 1'b1;
                            tx_st_ff <= TX_STOP;
                        end
                    end
                    TX_STOP: begin
                        if (bit_tick_ff) begin
                            if (stop2_ff & ~bs_mode) begin
                                stop2_ff <= 1'b0;
                            end else begin
                                txd_o <= 1'b1;
                                tx_ready_o <= 1'b1;
                                gap_ff <= tx_last_ff;
                                msg_start_ff <= tx_last_ff;
                                txcnt_ff <= (cnt_clr ? 16'h0 : txcnt_ff) + 16'h1;
                                tx_st_ff <= TX_IDLE;
                            end
                        end
                    end
                    default: tx_st_ff <= TX_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### inc/serial_tunnel_consts.vh
`ifndef SERIAL_TUNNEL_CONSTS_VH
`define SERIAL_TUNNEL_CONSTS_VH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_BAUD 8'h04
`define REG_LATENCY 8'h08
`define REG_TXDELAY 8'h0C
`define REG_IDLE 8'h10
`define REG_SYNC1 8'h14
`define REG_SYNC2 8'h18
`define REG_HSDELAY 8'h1C
`define REG_RXCNT 8'h20
`define REG_TXCNT 8'h24
`define REG_STATUS 8'h28
// Control field positions
`define CTRL_PORT_EN 0
`define CTRL_BITSTREAM 1
`define CTRL_FRAME 2
`define CTRL_P2P 3
`define CTRL_REMOTE 4
`define CTRL_RTSCTS 5
`define CTRL_DTRDSR 6
`define CTRL_CNT_CLR 7
`define CTRL_PAR_LO 8
`define CTRL_PAR_HI 9
`define CTRL_STOP2 10
`define CTRL_NB_LO 11
`define CTRL_NB_HI 12
`define CTRL_MASK 16'h1F7F
// Parity encodings
`define PAR_ODD 2'h1
`define PAR_EVEN 2'h2
// Reset values
`define RST_CTRL 16'h1800
`define RST_BAUD 16'h0411
`define RST_LATENCY 16'h000A
`define RST_TXDELAY 16'h0000
`define RST_IDLE 16'h001E
`define RST_SYNC1 16'h0010
`define RST_SYNC2 16'h0010
`define RST_HSDELAY 16'h0000
// Timing
`define CLK_HZ 10000000
`define MS_PER_S 1000
// Clock cycles per millisecond at 10 MHz
`define MS_CYCLES 16'h2710
`endif

// ### verif/serial_tunnel_port_processor_sva.sv
`timescale 1ns/1ps
`default_nettype none
module serial_tunnel_port_processor_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Bus and streams
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_valid_i,
    input wire logic tx_ready_o,
    input wire logic pkt_valid_o,
    input wire logic pkt_end_o,
    // Handshake
    input wire logic cts_o,
    input wire logic dsr_o,
    input wire logic dcd_o
);
    // ------------
    // Port checks
    // ------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_take; tx_valid_i && tx_ready_o; endsequence
    property p_ack_next; s_req |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_ready_drop; s_take |=> !tx_ready_o; endproperty
    property p_valid_pulse; pkt_valid_o |=> !pkt_valid_o; endproperty
    property p_end_apart; pkt_end_o |-> !pkt_valid_o; endproperty
    property p_cts_dsr; !(cts_o && dsr_o); endproperty
    property p_dcd_dsr; !(dcd_o && dsr_o); endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack too long");
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    a_ready_drop: assert property (p_ready_drop)
        else $error("ready held after accept");
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("byte strobe too long");
    a_end_apart: assert property (p_end_apart)
        else $error("packet end with byte");
    a_cts_dsr: assert property (p_cts_dsr)
        else $error("cts and dsr together");
    a_dcd_dsr: assert property (p_dcd_dsr)
        else $error("dcd and dsr together");
endmodule
bind serial_tunnel_port_processor serial_tunnel_port_processor_sva u_sva (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .pkt_valid_o(pkt_valid_o), .pkt_end_o(pkt_end_o), .cts_o(cts_o), .dsr_o(dsr_o),
    .dcd_o(dcd_o));
`default_nettype wire

// ### verif/serial_equipment_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_equipment_model #(
    parameter int BIT_CYC = 8
) (
    // Clock and line
    input wire logic clk_i,
    output logic rxd_o,
    input wire logic txd_i,
    input wire logic rts_i,
    input wire logic cts_i,
    // Captured bytes
    output logic [7:0] got_o,
    output logic [7:0] got_cnt_o
);
    // ------------------
    // Framed characters
    // ------------------
    initial rxd_o = 1'b1;
    initial got_cnt_o = 8'h00;
    task automatic send_byte(input logic [7:0] b);
        while (rts_i && !cts_i) @(posedge clk_i);
        for (int i = -1; i < 9; i++) begin
            @(posedge clk_i);
            rxd_o <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
            repeat (BIT_CYC - 1) @(posedge clk_i);
        end
    endtask
    always begin
        @(negedge txd_i);
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_i);
            got_o[i] <= txd_i;
        end
        repeat (BIT_CYC) @(posedge clk_i);
        got_cnt_o <= got_cnt_o + 8'h01;
    end
endmodule
`default_nettype wire

// ### verif/serial_tunnel_port_processor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_tunnel_port_processor_tb_top;
    // ------
    // Bench
    // ------
    logic clk_i = 1'b0, arst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, tx_data_i = 8'h00, pkt_data_o, got, got_cnt;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic rts = 1'b0, dtr = 1'b1, link_req = 1'b1, tx_valid_i = 1'b0, wb_ack_o, rxd, txd_o, cts_o, dsr_o, dcd_o;
    logic link_req_o;
    logic pkt_valid_o, pkt_end_o, tx_ready_o;
    logic [15:0] rst_val [9] = '{16'h1800, 16'h0411, 16'h000A, 16'h0, 16'h001E, 16'h0010, 16'h0010, 16'h0, 16'h0};
    int error_cnt = 0, checks_done = 0, n;
    serial_tunnel_port_processor #(.CYC_PER_MS(16'd16)) u_serial_tunnel_port_processor (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd), .txd_o(txd_o),
        .rts_i(rts), .cts_o(cts_o), .dtr_i(dtr), .dsr_o(dsr_o), .dcd_o(dcd_o), .link_req_i(link_req),
        .link_req_o(link_req_o), .pkt_data_o(pkt_data_o), .pkt_valid_o(pkt_valid_o), .pkt_end_o(pkt_end_o),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_last_i(1'b0), .tx_ready_o(tx_ready_o));
    serial_equipment_model #(.BIT_CYC(8)) u_serial_equipment_model (.clk_i(clk_i), .rxd_o(rxd), .txd_i(txd_o),
        .rts_i(rts), .cts_i(cts_o), .got_o(got), .got_cnt_o(got_cnt));
    initial forever #50 clk_i = ~clk_i;
    task automatic report_and_stop;
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
        checks_done++;
        if (got_v !== exp_v) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp_v);
        wb(1'b0, adr, 32'h0);
        chk(rd, exp_v);
    endtask
    task automatic push(input logic [7:0] b);
        @(posedge clk_i);
        tx_data_i <= b;
        tx_valid_i <= 1'b1;
        do @(posedge clk_i); while (tx_ready_o !== 1'b1);
        tx_valid_i <= 1'b0;
        for (n = 0; txd_o !== 1'b0; n++) @(posedge clk_i);
    endtask
    initial begin
        #500000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rts <= 1'b1;
        for (int i = 0; i < 9; i++) rchk(8'(i * 4), {16'h0, rst_val[i]});
        rchk(8'h28, 32'h2);
        rchk(8'h3C, 32'h0);
        chk({cts_o, dsr_o, dcd_o, link_req_o}, 32'h0);
        wb(1'b1, 8'h04, 32'h8);
        wb(1'b1, 8'h0C, 32'h4);
        wb(1'b1, 8'h00, 32'h1829);
        while (cts_o !== 1'b1) @(negedge clk_i);
        chk(link_req_o, 32'h1);
        chk({dsr_o, dcd_o}, 32'h1);
        fork u_serial_equipment_model.send_byte(8'hA5); join_none
        while (pkt_valid_o !== 1'b1) @(negedge clk_i);
        chk(pkt_data_o, 32'hA5);
        for (n = 0; pkt_end_o !== 1'b1; n++) @(negedge clk_i);
        chk(n, 32'd80);
        rchk(8'h20, 32'h1);
        push(8'h3C);
        chk(32'(n >= 32 && n <= 42), 32'h1);
        while (got_cnt !== 8'h01) @(negedge clk_i);
        chk(got, 32'h3C);
        push(8'hC3);
        chk(32'(n <= 10), 32'h1);
        while (got_cnt !== 8'h02) @(negedge clk_i);
        chk(got, 32'hC3);
        while (tx_ready_o !== 1'b1) @(negedge clk_i);
        rchk(8'h24, 32'h2);
        rchk(8'h20, 32'h1);
        wb(1'b1, 8'h00, 32'h18A9);
        rchk(8'h00, 32'h1829);
        rchk(8'h20, 32'h0);
        rchk(8'h24, 32'h0);
        rts <= 1'b0;
        wb(1'b1, 8'h1C, 32'h2);
        wb(1'b1, 8'h00, 32'h1849);
        for (n = 0; dsr_o !== 1'b1; n++) @(negedge clk_i);
        chk(32'(n >= 8 && n <= 24), 32'h1);
        chk({cts_o, dcd_o}, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
